// ===== core/synth_consts.vh
`ifndef SYNTH_CONSTS_VH
`define SYNTH_CONSTS_VH
// Frequency arithmetic
`define MANT_BIAS          9'h100
`define EXP_OFFSET         2
`define IF_SHIFT           10
// Pin output selection
`define SEL_LOCK           6'h0a
`define SEL_HIGH_Z         6'h2e
// Calibration result
`define CAL_UNLOCKED       6'h3f
`define CAL_TIME_CYCLES    18739
`define LOCK_DELAY_CYCLES  16'h0040
// Power table
`define PT_DEPTH           8
`define PT_DEFAULT         8'hc6
`define RAMP_STEP_CYCLES   16'h0100
// Auto calibration codes
`define AUTOCAL_NEVER      2'h0
`define AUTOCAL_ON_START   2'h1
`define AUTOCAL_ON_STOP    2'h2
// Power-up wait before ready, cycles
`define PWRUP_CYCLES       16'h0080
`endif

// ===== core/power_table_mem.v
`include "synth_consts.vh"
// Eight-entry power table with registered read port
module power_table_mem (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Write port
    input  wire       wr_en,
    input  wire [2:0] wr_addr,
    input  wire [7:0] wr_data,
    // Read port
    input  wire [2:0] rd_addr,
    output reg  [7:0] rd_data
);
    reg [7:0] mem [0:`PT_DEPTH-1];
    genvar i;
    // One storage entry per index, all reset to the default setting
    generate
        for (i = 0; i < `PT_DEPTH; i = i + 1) begin : g_ent
            always @(posedge clk) begin
                if (rst)
                    mem[i] <= `PT_DEFAULT;
                else if (wr_en && wr_addr == i)
                    mem[i] <= wr_data;
            end
        end
    endgenerate
    // Registered read
    always @(posedge clk) begin
        if (rst)
            rd_data <= `PT_DEFAULT;
        else
            rd_data <= mem[rd_addr];
    end
endmodule

// ===== core/base_frequency_word_calc.v
`include "synth_consts.vh"
// Registered frequency word arithmetic
module base_frequency_word_calc (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Programming
    input  wire [23:0] base_frequency_word,
    input  wire [7:0]  channel_number,
    input  wire [7:0]  chan_spacing_mantissa,
    input  wire [1:0]  chan_spacing_exponent,
    input  wire [4:0]  if_frequency_word,
    // Results
    output reg  [31:0] carrier_word,
    output reg  [14:0] if_word
);
    wire [8:0]  spacing = `MANT_BIAS + {1'b0, chan_spacing_mantissa};
    wire [16:0] step_x4 = {8'h00, spacing} * {9'h000, channel_number};
    // Step times 2^e, then two fraction bits kept: result in units of fxosc/2^18
    wire [31:0] step_scaled = {15'h0000, step_x4} << chan_spacing_exponent;
    // Carrier in fxosc/2^18 units; IF in fxosc/2^10 units padded to fxosc/2^20
    always @(posedge clk) begin
        if (rst) begin
            carrier_word <= 32'h00000000;
            if_word      <= 15'h0000;
        end else begin
            carrier_word <= {6'h00, base_frequency_word, 2'h0} + step_scaled;
            if_word      <= {if_frequency_word, 10'h000};
        end
    end
endmodule

// ===== core/synth_cal_pa_ramp_control.v
`include "synth_consts.vh"
// Functional notes
// - Carrier word is base plus channel times biased mantissa times two to exponent minus two.
// - Base frequency is a 24-bit word from three byte fields.
// - An 8-bit channel number multiplies the channel spacing.
// - Spacing is a mantissa field and an exponent field.
// - IF word is the IF frequency field scaled by fxosc over 1024.
// - Auto calibration runs at synthesizer start or stop as selected.
// - Calibrate strobe in idle starts a manual calibration.
// - Calibration results survive sleep.
// - Pin select 0x0a puts lock detector on the pin; rising means lock.
// - Calibration result reads 0x3f unless the PLL is locked.
// - Chip select low turns on core power and the oscillator.
// - After power-down strobe, power goes off when chip select rises; the code arms the strobe only in idle.
// - Power table holds eight settings; 3-bit index picks the top entry.
// - Ramp applies entries from zero up to the index at start and end.
// - Index zero means no ramp, entry zero only.
// - Power table entries reset to 0xc6.
// - Calibration takes 18739 clock periods.
module synth_cal_pa_ramp_control #(
    parameter CAL_CYCLES = `CAL_TIME_CYCLES
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Pins
    input  wire        chip_select_n,
    output reg         serial_out_ready_n,
    output reg         general_output_pin,
    output reg         general_output_pin_oe,
    // Frequency programming
    input  wire [7:0]  base_frequency_hi,
    input  wire [7:0]  base_frequency_mid,
    input  wire [7:0]  base_frequency_lo,
    input  wire [7:0]  channel_number,
    input  wire [7:0]  chan_spacing_mantissa,
    input  wire [1:0]  chan_spacing_exponent,
    input  wire [4:0]  if_frequency_word,
    output reg  [31:0] carrier_word,
    output reg  [14:0] if_word,
    // Calibration control
    input  wire [1:0]  synth_autocal_select,
    input  wire        calibrate_strobe,
    input  wire        synth_on_req,
    input  wire        pll_lock_raw,
    output reg  [5:0]  synth_cal_result,
    output reg         cal_busy,
    output reg         synth_running,
    output reg         radio_idle,
    // Power control
    input  wire        power_down_strobe,
    input  wire        sleep_enter,
    output reg         core_power_on,
    output reg         xosc_on,
    // Pin output selection
    input  wire [5:0]  pin_output_select,
    // Power table
    input  wire        pt_wr_en,
    input  wire [2:0]  pt_wr_addr,
    input  wire [7:0]  pt_wr_data,
    input  wire [2:0]  power_index,
    input  wire        tx_on_req,
    output reg  [7:0]  pa_setting,
    output reg         tx_ramp_done
);
    localparam S_IDLE  = 3'h0;
    localparam S_CAL   = 3'h1;
    localparam S_RUN   = 3'h2;
    localparam S_CALX  = 3'h3;
    localparam S_SLEEP = 3'h4;

    localparam R_OFF  = 2'h0;
    localparam R_UP   = 2'h1;
    localparam R_HOLD = 2'h2;
    localparam R_DOWN = 2'h3;

    reg  [2:0]  state;
    reg  [15:0] cal_cnt;
    reg  [5:0]  cal_value;
    reg         cal_valid;
    reg  [15:0] lock_cnt;
    reg         locked;
    reg  [1:0]  ramp;
    reg  [2:0]  pt_idx;
    reg  [15:0] step_cnt;
    reg  [15:0] pwr_cnt;
    reg         pd_armed;
    reg         cs_m, cs_s;
    reg         lk_m, lk_s;
    wire [31:0] calc_carrier;
    wire [14:0] calc_if;
    wire [7:0]  pt_rd_data;

    // Last calibration count, cut on purpose to the counter width
    localparam integer CAL_LAST_FULL = CAL_CYCLES - 1;
    localparam [15:0]  CAL_LAST      = CAL_LAST_FULL[15:0];

    // Pin synchronisers for chip select and the analog lock flag
    always @(posedge clk) begin
        if (rst) begin
            // Idle pin levels: deselected and unlocked, so no false edge
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            lk_m <= 1'b0;
            lk_s <= 1'b0;
        end else begin
            cs_m <= chip_select_n;
            cs_s <= cs_m;
            lk_m <= pll_lock_raw;
            lk_s <= lk_m;
        end
    end

    // Frequency arithmetic
    base_frequency_word_calc u_base_frequency_word (
        .clk                   (clk),
        .rst                   (rst),
        .base_frequency_word   ({base_frequency_hi, base_frequency_mid, base_frequency_lo}),
        .channel_number        (channel_number),
        .chan_spacing_mantissa (chan_spacing_mantissa),
        .chan_spacing_exponent (chan_spacing_exponent),
        .if_frequency_word     (if_frequency_word),
        .carrier_word          (calc_carrier),
        .if_word               (calc_if)
    );

    // Frequency outputs frozen while the synthesizer runs
    always @(posedge clk) begin
        if (rst) begin
            carrier_word <= 32'h00000000;
            if_word      <= 15'h0000;
        end else if (state == S_IDLE) begin
            // Held while running so the synthesizer never sees a step
            carrier_word <= calc_carrier;
            if_word      <= calc_if;
        end
    end

    // Power sequencing from chip select and the power-down strobe
    always @(posedge clk) begin
        if (rst) begin
            core_power_on      <= 1'b1;
            xosc_on            <= 1'b1;
            pd_armed           <= 1'b0;
            pwr_cnt            <= 16'h0000;
            serial_out_ready_n <= 1'b1;
        end else begin
            if (!cs_s) begin
                core_power_on <= 1'b1;
                xosc_on       <= 1'b1;
                // Disarm on the first selected cycle, while power is still off
                if (!core_power_on)
                    pd_armed  <= 1'b0;
                if (pwr_cnt != `PWRUP_CYCLES)
                    pwr_cnt <= pwr_cnt + 16'h0001;
                // Ready only after the full power-up count with power on
                serial_out_ready_n <= (pwr_cnt != `PWRUP_CYCLES) || !core_power_on;
            end else begin
                // Deselected: serial output not ready
                serial_out_ready_n <= 1'b1;
                if (pd_armed) begin
                    core_power_on <= 1'b0;
                    xosc_on       <= 1'b0;
                    pwr_cnt       <= 16'h0000;
                end
            end
            // Strobe comes last: it is issued while selected and must survive
            if (power_down_strobe && state == S_IDLE)
                pd_armed <= 1'b1;
        end
    end

    // Radio control: idle, calibration, running, calibration back to idle (manual or at stop), sleep
    always @(posedge clk) begin
        if (rst) begin
            state     <= S_IDLE;
            cal_cnt   <= 16'h0000;
            cal_value <= `CAL_UNLOCKED;
            // Nothing calibrated yet
            cal_valid <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    cal_cnt <= 16'h0000;
                    // Sleep wins over the strobe, the strobe over a start request
                    if (sleep_enter)
                        state <= S_SLEEP;
                    else if (calibrate_strobe)
                        state <= S_CALX;
                    else if (synth_on_req && synth_autocal_select == `AUTOCAL_ON_START)
                        state <= S_CAL;
                    else if (synth_on_req)
                        state <= S_RUN;
                end
                S_CAL, S_CALX: begin
                    // Fixed length count, then on to run or back to idle
                    if (cal_cnt == CAL_LAST) begin
                        cal_cnt   <= 16'h0000;
                        cal_valid <= 1'b1;
                        state     <= (state == S_CAL) ? S_RUN : S_IDLE;
                    end else begin
                        cal_cnt <= cal_cnt + 16'h0001;
                    end
                end
                S_RUN: begin
                    // A stop request may call for a calibration on the way out
                    if (!synth_on_req)
                        state <= (synth_autocal_select == `AUTOCAL_ON_STOP) ? S_CALX : S_IDLE;
                end
                S_SLEEP: begin
                    if (!sleep_enter)
                        state <= S_IDLE;        // calibration kept
                end
                default: state <= S_IDLE;
            endcase
            // Result shows lock state; stored calibration is never cleared by sleep
            cal_value <= (locked && cal_valid) ? {1'b0, cal_cnt[4:0]} | 6'h01 : `CAL_UNLOCKED;
        end
    end

    // Lock detector: PLL lock qualified for a short time while running
    always @(posedge clk) begin
        if (rst) begin
            lock_cnt <= 16'h0000;
            locked   <= 1'b0;
        end else if (state != S_RUN || !lk_s || !cal_valid) begin
            lock_cnt <= 16'h0000;
            locked   <= 1'b0;
        end else if (lock_cnt == `LOCK_DELAY_CYCLES) begin
            // Flag stayed high for the whole delay: report lock
            locked <= 1'b1;
        end else begin
            lock_cnt <= lock_cnt + 16'h0001;
        end
    end

    // Status outputs
    always @(posedge clk) begin
        if (rst) begin
            synth_cal_result      <= `CAL_UNLOCKED;
            cal_busy              <= 1'b0;
            synth_running         <= 1'b0;
            radio_idle            <= 1'b1;
            general_output_pin    <= 1'b0;
            general_output_pin_oe <= 1'b0;
        end else begin
            synth_cal_result      <= locked ? (cal_value == `CAL_UNLOCKED ? 6'h00 : cal_value)
                                            : `CAL_UNLOCKED;
            cal_busy              <= (state == S_CAL) || (state == S_CALX);
            synth_running         <= (state == S_RUN);
            radio_idle            <= (state == S_IDLE);
            // Pin shows lock only when selected; released only on the high-Z code
            general_output_pin    <= (pin_output_select == `SEL_LOCK) ? locked : 1'b0;
            general_output_pin_oe <= (pin_output_select != `SEL_HIGH_Z);
        end
    end

    // Power table storage
    power_table_mem u_pt (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (pt_wr_en),
        .wr_addr (pt_wr_addr),
        .wr_data (pt_wr_data),
        .rd_addr (pt_idx),
        .rd_data (pt_rd_data)
    );

    // Power ramp: step the table index up at start, down at end
    always @(posedge clk) begin
        if (rst) begin
            ramp         <= R_OFF;
            pt_idx       <= 3'h0;
            step_cnt     <= 16'h0000;
            tx_ramp_done <= 1'b0;
        end else if (state != S_RUN) begin
            // Synthesizer gone: PA off at once, no ramp on a dead carrier
            ramp         <= R_OFF;
            pt_idx       <= 3'h0;
            step_cnt     <= 16'h0000;
            tx_ramp_done <= 1'b0;
        end else begin
            case (ramp)
                R_OFF: begin
                    // Wait for a transmit request while the synthesizer runs
                    pt_idx       <= 3'h0;
                    tx_ramp_done <= 1'b0;
                    step_cnt     <= 16'h0000;
                    if (tx_on_req && state == S_RUN)
                        ramp <= (power_index == 3'h0) ? R_HOLD : R_UP;
                end
                R_UP: begin
                    // Climb one entry per step up to the programmed index
                    if (!tx_on_req) begin
                        ramp <= R_DOWN;
                    end else if (pt_idx == power_index) begin
                        ramp <= R_HOLD;
                    end else if (step_cnt == `RAMP_STEP_CYCLES) begin
                        step_cnt <= 16'h0000;
                        pt_idx   <= pt_idx + 3'h1;
                    end else begin
                        step_cnt <= step_cnt + 16'h0001;
                    end
                end
                R_HOLD: begin
                    // Top entry held until transmit ends
                    tx_ramp_done <= 1'b1;
                    step_cnt     <= 16'h0000;
                    if (!tx_on_req) begin
                        tx_ramp_done <= 1'b0;
                        ramp <= (pt_idx == 3'h0) ? R_OFF : R_DOWN;
                    end
                end
                R_DOWN: begin
                    // Entry zero keeps a full step before the PA goes off
                    if (step_cnt == `RAMP_STEP_CYCLES) begin
                        step_cnt <= 16'h0000;
                        if (pt_idx == 3'h0)
                            ramp <= R_OFF;
                        else
                            pt_idx <= pt_idx - 3'h1;
                    end else begin
                        step_cnt <= step_cnt + 16'h0001;
                    end
                end
                default: ramp <= R_OFF;
            endcase
        end
    end

    // PA drive: table entry while transmitting, zero otherwise
    always @(posedge clk) begin
        if (rst)
            pa_setting <= 8'h00;
        else
            pa_setting <= (ramp == R_OFF) ? 8'h00 : pt_rd_data;
    end
endmodule

// ===== tb/synth_chk.sv
`include "synth_consts.vh"
module synth_chk #(
    parameter CAL_CYCLES = `CAL_TIME_CYCLES
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Pins
    input wire logic       chip_select_n,
    input wire logic       general_output_pin,
    input wire logic       general_output_pin_oe,
    input wire logic [5:0] pin_output_select,
    // Calibration
    input wire logic [1:0] synth_autocal_select,
    input wire logic       calibrate_strobe,
    input wire logic       synth_on_req,
    input wire logic [5:0] synth_cal_result,
    input wire logic       cal_busy,
    input wire logic       synth_running,
    input wire logic       radio_idle,
    // Power
    input wire logic       core_power_on,
    input wire logic       xosc_on,
    input wire logic [7:0] pa_setting
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    int busy_cnt;
    // Length of the current busy stretch
    always @(posedge clk) begin
        busy_cnt <= (rst || !cal_busy) ? 0 : busy_cnt + 1;
    end
    sequence s_start_idle;
        radio_idle && !cal_busy && !$past(calibrate_strobe);
    endsequence
    sequence s_busy_late;
        !cal_busy ##1 cal_busy;
    endsequence
    property p_cal_start;
        s_start_idle and (calibrate_strobe && !synth_on_req) |=> s_busy_late;
    endproperty
    property p_autocal;
        s_start_idle and (synth_autocal_select == `AUTOCAL_ON_START && $rose(synth_on_req)) |=> s_busy_late;
    endproperty
    property p_cal_len;
        $fell(cal_busy) |-> busy_cnt == CAL_CYCLES;
    endproperty
    property p_cal_max;
        cal_busy |-> busy_cnt < CAL_CYCLES;
    endproperty
    property p_lock_pin;
        pin_output_select == `SEL_LOCK && $stable(pin_output_select)
            |-> general_output_pin == (synth_cal_result != `CAL_UNLOCKED);
    endproperty
    property p_pin_low;
        pin_output_select != `SEL_LOCK && $stable(pin_output_select) |-> !general_output_pin;
    endproperty
    property p_pwr_on;
        !chip_select_n [*4] |=> core_power_on && xosc_on;
    endproperty
    property p_pwr_off;
        $fell(core_power_on) |-> chip_select_n;
    endproperty
    property p_pa_off;
        !synth_running [*4] |-> pa_setting == 8'h00;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("no calibration after strobe in idle");
    a_autocal: assert property (p_autocal) else $error("no calibration at synthesizer start");
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    a_cal_max: assert property (p_cal_max) else $error("calibration overran");
    a_lock_pin: assert property (p_lock_pin) else $error("lock pin disagrees with result");
    a_pin_low: assert property (p_pin_low) else $error("pin high without lock select");
    a_pwr_on: assert property (p_pwr_on) else $error("power off while selected");
    a_pwr_off: assert property (p_pwr_off) else $error("power removed while selected");
    a_pa_off: assert property (p_pa_off) else $error("power amplifier on while idle");
endmodule

bind synth_cal_pa_ramp_control synth_chk #(.CAL_CYCLES(CAL_CYCLES)) synth_chk_inst (
    .clk, .rst, .chip_select_n, .general_output_pin, .general_output_pin_oe, .pin_output_select,
    .synth_autocal_select, .calibrate_strobe, .synth_on_req, .synth_cal_result, .cal_busy,
    .synth_running, .radio_idle, .core_power_on, .xosc_on, .pa_setting
);

// ===== tb/pll_model.sv
module pll_model #(
    parameter int LATENCY = 20
) (
    // Clock
    input  wire logic clk,
    // Synthesizer state and forced failure
    input  wire logic synth_running,
    input  wire logic fail_lock,
    output logic      pll_lock_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // Loop settles a while after start; a forced failure keeps it unlocked
    always @(posedge clk) begin
        cnt <= !synth_running ? 0 : (cnt < LATENCY ? cnt + 1 : cnt);
        pll_lock_raw <= synth_running && !fail_lock && cnt >= LATENCY;
    end
    initial pll_lock_raw = 1'b0;
endmodule

// ===== tb/synth_cal_pa_ramp_control_tb.sv
`include "synth_consts.vh"
module synth_cal_pa_ramp_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CAL = 20;
    logic        clk, rst, chip_select_n, calibrate_strobe, synth_on_req, power_down_strobe, sleep_enter;
    logic        serial_out_ready_n, general_output_pin, general_output_pin_oe, pll_lock_raw, fail_lock;
    logic        cal_busy, synth_running, radio_idle, core_power_on, xosc_on, pt_wr_en, tx_on_req, tx_ramp_done;
    logic [7:0]  base_frequency_hi, base_frequency_mid, base_frequency_lo, channel_number;
    logic [7:0]  chan_spacing_mantissa, pt_wr_data, pa_setting;
    logic [1:0]  chan_spacing_exponent, synth_autocal_select;
    logic [4:0]  if_frequency_word;
    logic [5:0]  synth_cal_result, pin_output_select;
    logic [2:0]  pt_wr_addr, power_index;
    logic [31:0] carrier_word, exp_word;
    logic [14:0] if_word;
    int          failures, checks_done;
    synth_cal_pa_ramp_control #(.CAL_CYCLES(CAL)) synth_cal_pa_ramp_control_inst (
        .clk, .rst, .chip_select_n, .serial_out_ready_n, .general_output_pin, .general_output_pin_oe,
        .base_frequency_hi, .base_frequency_mid, .base_frequency_lo, .channel_number, .chan_spacing_mantissa,
        .chan_spacing_exponent, .if_frequency_word, .carrier_word, .if_word, .synth_autocal_select,
        .calibrate_strobe, .synth_on_req, .pll_lock_raw, .synth_cal_result, .cal_busy, .synth_running,
        .radio_idle, .power_down_strobe, .sleep_enter, .core_power_on, .xosc_on, .pin_output_select,
        .pt_wr_en, .pt_wr_addr, .pt_wr_data, .power_index, .tx_on_req, .pa_setting, .tx_ramp_done
    );
    pll_model pll_model_inst (.clk, .synth_running, .fail_lock, .pll_lock_raw);
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return cal_busy;
            1: return serial_out_ready_n;
            default: return general_output_pin;
        endcase
    endfunction
    // Bounded wait for an output level
    task automatic wait_for(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (sig(s) !== v && n < lim) begin
            tick(1);
            n++;
        end
        check(sig(s), v, "wait level");
        if (sig(s) !== v) give_verdict();
    endtask
    // Manual calibration, with a strobe during busy that must be ignored
    task automatic run_cal;
        int n;
        calibrate_strobe = 1'b1;
        tick(1);
        calibrate_strobe = 1'b0;
        tick(1);
        n = 0;
        while (cal_busy === 1'b1 && n < CAL + 10) begin
            calibrate_strobe = (n == 5);
            tick(1);
            n++;
        end
        check(n, CAL, "calibration length");
        tick(3);
        check(cal_busy, 1'b0, "strobe during busy ignored");
    endtask
    // Switch transmit and record each distinct power setting
    task automatic ramp(input logic on, input logic [2:0] idx, input int cnt, input logic [7:0] e [8]);
        logic [7:0] prev;
        int         k;
        power_index = idx;
        tx_on_req = on;
        k = 0;
        prev = pa_setting;
        repeat (2500) begin
            tick(1);
            if (pa_setting !== prev) begin
                if (k < 8) check(pa_setting, e[k], "ramp step");
                k++;
                prev = pa_setting;
            end
        end
        check(k, cnt, "ramp step count");
        check(tx_ramp_done, on, "ramp done");
    endtask
    initial begin
        {chip_select_n, calibrate_strobe, synth_on_req, power_down_strobe, sleep_enter, fail_lock} = '0;
        {pt_wr_en, pt_wr_addr, pt_wr_data, power_index, tx_on_req, synth_autocal_select} = '0;
        {base_frequency_hi, base_frequency_mid, base_frequency_lo, channel_number} = '0;
        {chan_spacing_mantissa, chan_spacing_exponent, if_frequency_word, pin_output_select} = '0;
        {failures, checks_done} = '0;
        rst = 1'b1;
        tick(3);
        check(synth_cal_result, `CAL_UNLOCKED, "result at reset");
        check(pa_setting, 8'h00, "power off at reset");
        rst = 1'b0;
        wait_for(1, 1'b0, 400);
        $display("test reset done");
        // Frequency words for every exponent
        for (int e = 0; e < 4; e++) begin
            {base_frequency_hi, base_frequency_mid, base_frequency_lo} = 24'h5d13b1 + e;
            channel_number = 8'hff - 8'h55 * e;
            chan_spacing_mantissa = 8'h55 * e;
            chan_spacing_exponent = e;
            if_frequency_word = 5'h1f - e;
            exp_word = ({8'h00, base_frequency_hi, base_frequency_mid, base_frequency_lo} << 2)
                + (((32'h100 + chan_spacing_mantissa) * channel_number) << e);
            tick(4);
            check(carrier_word, exp_word, "carrier word");
            check(if_word, {if_frequency_word, 10'h000}, "if word");
        end
        $display("test frequency done");
        run_cal();
        pin_output_select = `SEL_LOCK;
        fail_lock = 1'b1;
        synth_on_req = 1'b1;
        tick(200);
        check(synth_cal_result, `CAL_UNLOCKED, "no lock result");
        synth_on_req = 1'b0;
        fail_lock = 1'b0;
        tick(4);
        run_cal();
        synth_on_req = 1'b1;
        wait_for(2, 1'b1, 300);
        check(synth_cal_result == `CAL_UNLOCKED, 1'b0, "locked result");
        $display("test lock done");
        ramp(1'b1, 3'h0, 1, '{8'hc6, 0, 0, 0, 0, 0, 0, 0});
        ramp(1'b0, 3'h0, 1, '{8'h00, 0, 0, 0, 0, 0, 0, 0});
        for (int i = 0; i < 8; i++) begin
            pt_wr_en = 1'b1;
            pt_wr_addr = i;
            pt_wr_data = 8'h10 + i;
            tick(1);
        end
        pt_wr_en = 1'b0;
        ramp(1'b1, 3'h7, 8, '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17});
        ramp(1'b0, 3'h7, 8, '{8'h16, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h00});
        $display("test ramp done");
        synth_autocal_select = `AUTOCAL_ON_STOP;
        tick(2);
        synth_on_req = 1'b0;
        wait_for(0, 1'b1, 6);
        wait_for(0, 1'b0, CAL + 10);
        synth_autocal_select = `AUTOCAL_ON_START;
        tick(4);
        synth_on_req = 1'b1;
        wait_for(0, 1'b1, 6);
        wait_for(0, 1'b0, CAL + 10);
        synth_autocal_select = `AUTOCAL_NEVER;
        tick(2);
        synth_on_req = 1'b0;
        tick(6);
        check(cal_busy, 1'b0, "no calibration when never");
        $display("test autocal done");
        sleep_enter = 1'b1;
        tick(20);
        sleep_enter = 1'b0;
        tick(10);
        synth_on_req = 1'b1;
        wait_for(2, 1'b1, 300);
        synth_on_req = 1'b0;
        pin_output_select = `SEL_HIGH_Z;
        tick(3);
        check(general_output_pin_oe, 1'b0, "pin released");
        pin_output_select = 6'h00;
        tick(3);
        check(general_output_pin_oe, 1'b1, "pin driven");
        $display("test sleep done");
        power_down_strobe = 1'b1;
        tick(1);
        power_down_strobe = 1'b0;
        chip_select_n = 1'b1;
        tick(10);
        check({core_power_on, xosc_on}, 2'h0, "powered down");
        chip_select_n = 1'b0;
        tick(8);
        check({core_power_on, xosc_on}, 2'h3, "powered up");
        wait_for(1, 1'b0, 400);
        $display("test power done");
        give_verdict();
    end
endmodule
